// ==== src/wdog_pkg.sv ====
package wdog_pkg;
	localparam int unsigned CLK_HZ          = 20_000_000;
	localparam int unsigned TICK_SEC        = 1;
	localparam int unsigned TICK_CYCLES     = CLK_HZ * TICK_SEC;
	localparam int unsigned STARTUP_SEC     = 150;
	localparam int unsigned RELAY_PULSE_SEC = 4;
	localparam int unsigned SEC_W           = 12;
	localparam int unsigned HOST_RST_CYCLES = 20;

	localparam logic [11:0] ADDR_CTRL    = 12'h000;
	localparam logic [11:0] ADDR_STATUS  = 12'h004;
	localparam logic [11:0] ADDR_TIMEOUT = 12'h008;
	localparam logic [11:0] ADDR_TRIG    = 12'h00c;

	localparam int unsigned CTRL_R1_INVERT = 0;
	localparam int unsigned CTRL_R2_OWN    = 1;
	localparam int unsigned CTRL_R2_VALUE  = 2;
	localparam int unsigned CTRL_R1_OFF    = 3;
	localparam int unsigned CTRL_R2_OFF    = 4;
	localparam int unsigned CTRL_TO_OWN    = 5;
	localparam int unsigned CTRL_CLR_RST   = 6;

	localparam logic [31:0] CTRL_RESET    = 32'h0000_0000;
	localparam logic [31:0] TIMEOUT_RESET = 32'h0000_0005;

	typedef enum logic [3:0] {
		ST_HOLDOFF = 4'b0001,
		ST_WAITTRG = 4'b0010,
		ST_ARMED   = 4'b0100,
		ST_TRIP    = 4'b1000
	} wd_state_t;

	typedef struct packed {
		logic relay1_temp_enable;
		logic relay1_latch_mode;
		logic relay2_latch_mode;
		logic overtemp_hold_reset_enable;
		logic startup_hold_delay;
		logic [2:0] delay_sel;
	} switches_t;

	typedef struct packed {
		logic lower_trip;
		logic upper_trip;
		logic release_band;
	} temp_t;

	function automatic logic [SEC_W-1:0] sel_seconds(input logic [2:0] s);
		case (s)
			3'h0: sel_seconds = 12'h005;
			3'h1: sel_seconds = 12'h00a;
			3'h2: sel_seconds = 12'h01e;
			3'h3: sel_seconds = 12'h03c;
			3'h4: sel_seconds = 12'h12c;
			3'h5: sel_seconds = 12'h258;
			3'h6: sel_seconds = 12'h708;
			default: sel_seconds = 12'he10;
		endcase
	endfunction : sel_seconds
endpackage : wdog_pkg

// ==== src/switch_configured_watchdog.sv ====
`timescale 1ns/1ps
//Contract
//RQ1: relay-one temp switch on: lower trip fires relay one in its mode; else ignored
//RQ2: pulse mode: each fresh rise above lower trip gives a new relay-one pulse
//RQ3: relay-one latch mode latches relay one on watchdog or enabled temp trip
//RQ4: relay-one pulse mode gives a 4-5 second pulse per trip
//RQ5: latched relays clear only on power-down, panel reset, or software off
//RQ6: software option inverts relay-one mode switch and relay-one sense
//RQ7: relay-two latch mode latches on watchdog trip; temperature ignored
//RQ8: relay-two pulse mode gives 4-5 second pulse per watchdog trip
//RQ9: software may take exclusive control of relay two
//RQ10: overtemp reset switch on: hold host reset from the upper trip
//RQ11: release overtemp reset once temperature reaches lower trip plus 4 degrees
//RQ12: overtemp reset switch off: upper trip only changes buzzer pattern
//RQ13: extend off: wait 150 s after power-on or host reset, then arm
//RQ14: extend on: after 150 s wait for first re-trigger before arming
//RQ15: delay switches select 5 s to 1 h timeout, switch six most significant
//RQ16: armed: each re-trigger restarts count; expiry starts host reset
//RQ17: software timeout replaces the switch selection when enabled
//RQ18: panel reset button resets this logic and passes through to host
//RQ19: host keeps extend switch off and prefers a longer stored delay
//RQ20: other party re-triggers with rising edges faster than the timeout
//RQ21: after host reset a sticky status bit is set until software clears it
//RQ22: all delays count a one-second timebase from the system clock; the host reset pulse counts HOST_RST_CYCLES clock cycles instead
//RQ23: expiry pulses host reset, triggers both relays, reenters the startup delay
module switch_configured_watchdog
	import wdog_pkg::*;
#(
	parameter int unsigned TICK_CYC = TICK_CYCLES
) (
	// apb
	input  wire logic        pclk,
	input  wire logic        presetn,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [11:0] paddr,
	input  wire logic [31:0] pwdata,
	input  wire logic [3:0]  pstrb,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	// board
	input  wire switches_t   sw,
	input  wire temp_t       temp,
	input  wire logic        ext_trigger,
	input  wire logic        panel_reset_n,
	// outputs
	output logic             host_reset_n,
	output logic             relay1,
	output logic             relay2,
	output logic             buzzer_continuous,
	output logic             reset_seen_led
);
	localparam int unsigned TW = $clog2(TICK_CYC + 1);

	// panel reset folds into logic reset [RQ18]
	wire rst_n = presetn & panel_reset_n; // [RQ18]

	logic [TW-1:0]    tick_cnt_q;
	logic             tick_q;
	wd_state_t        st_q;
	logic [SEC_W-1:0] sec_q;
	logic [SEC_W-1:0] r1_cnt_q;
	logic [SEC_W-1:0] r2_cnt_q;
	logic             r1_latch_q;
	logic             r2_latch_q;
	logic             rst_seen_q;
	logic             ot_hold_q;
	logic             lower_q;
	logic             ext_q;
	logic [7:0]       hr_cnt_q;
	logic [31:0]      ctrl_q;
	logic [SEC_W-1:0] sw_to_q;
	logic             sw_trig_q;

	// apb decode
	wire acc     = psel & penable;
	wire wr      = acc & pwrite;
	wire hit_c   = paddr == ADDR_CTRL;
	wire hit_s   = paddr == ADDR_STATUS;
	wire hit_t   = paddr == ADDR_TIMEOUT;
	wire hit_g   = paddr == ADDR_TRIG;
	wire mapped  = hit_c | hit_s | hit_t | hit_g;
	wire wr_c    = wr & hit_c & pstrb[0];
	wire wr_t    = wr & hit_t & (pstrb[1:0] == 2'b11);
	wire wr_g    = wr & hit_g;
	assign pready  = 1'b1;
	assign pslverr = acc & ~mapped;

	// one-second timebase [RQ22]
	wire tick_wrap = tick_cnt_q == TW'(TICK_CYC - 1);
	always_ff @(posedge pclk or negedge rst_n) begin
		if (!rst_n) begin
			tick_cnt_q <= '0;
			tick_q     <= 1'b0;
		end else begin
			tick_cnt_q <= tick_wrap ? '0 : tick_cnt_q + TW'(1); // [RQ22]
			tick_q     <= tick_wrap;
		end
	end

	// re-trigger: rising external edge or software write [RQ20]
	wire retrig  = (ext_trigger & ~ext_q) | sw_trig_q; // [RQ20]
	wire [SEC_W-1:0] timeout_s = ctrl_q[CTRL_TO_OWN] ? sw_to_q : sel_seconds(sw.delay_sel); // [RQ15] [RQ17]
	wire expire  = (st_q == ST_ARMED) & tick_q & (sec_q <= SEC_W'(1)); // [RQ16]
	wire hold_done = tick_q & (sec_q <= SEC_W'(1));

	wd_state_t st_d;
	logic [SEC_W-1:0] sec_d;
	always_comb begin
		st_d  = st_q;
		sec_d = tick_q ? sec_q - SEC_W'(1) : sec_q;
		case (st_q)
			ST_HOLDOFF: if (hold_done) begin // [RQ13]
				st_d  = sw.startup_hold_delay ? ST_WAITTRG : ST_ARMED; // [RQ14]
				sec_d = timeout_s;
			end
			ST_WAITTRG: begin
				sec_d = timeout_s;
				if (retrig)
					st_d = ST_ARMED; // [RQ14]
			end
			ST_ARMED: begin
				if (retrig)
					sec_d = timeout_s; // [RQ16]
				else if (expire)
					st_d = ST_TRIP;
			end
			ST_TRIP: begin
				st_d  = ST_HOLDOFF; // [RQ23]
				sec_d = SEC_W'(STARTUP_SEC);
			end
			default: begin
				st_d  = ST_HOLDOFF;
				sec_d = SEC_W'(STARTUP_SEC);
			end
		endcase
	end

	always_ff @(posedge pclk or negedge rst_n) begin
		if (!rst_n) begin
			st_q  <= ST_HOLDOFF;
			sec_q <= SEC_W'(STARTUP_SEC);
		end else begin
			st_q  <= st_d;
			sec_q <= sec_d;
		end
	end

	wire wd_trip = st_q == ST_TRIP;
	// temperature event: rising over lower trip [RQ1] [RQ2]
	wire t_event = sw.relay1_temp_enable & temp.lower_trip & ~lower_q; // [RQ1] [RQ2]
	wire r1_fire = wd_trip | t_event;
	wire r1_latch_sel = sw.relay1_latch_mode ^ ctrl_q[CTRL_R1_INVERT]; // [RQ6]
	wire r1_off  = wr_c & pwdata[CTRL_R1_OFF];
	wire r2_off  = wr_c & pwdata[CTRL_R2_OFF];

	always_ff @(posedge pclk or negedge rst_n) begin
		if (!rst_n) begin
			r1_latch_q <= 1'b0;
			r2_latch_q <= 1'b0;
			r1_cnt_q   <= '0;
			r2_cnt_q   <= '0;
		end else begin
			// set beats a same-cycle software off [RQ5]
			if (r1_fire & r1_latch_sel)
				r1_latch_q <= 1'b1; // [RQ3]
			else if (r1_off)
				r1_latch_q <= 1'b0; // [RQ5]
			if (wd_trip & sw.relay2_latch_mode)
				r2_latch_q <= 1'b1; // [RQ7]
			else if (r2_off)
				r2_latch_q <= 1'b0; // [RQ5]
			// pulse counts RELAY_PULSE_SEC full ticks plus a partial: 4-5 s
			if (r1_fire & ~r1_latch_sel)
				r1_cnt_q <= SEC_W'(RELAY_PULSE_SEC + 1); // [RQ4]
			else if (r1_off)
				r1_cnt_q <= '0;
			else if (tick_q && r1_cnt_q != '0)
				r1_cnt_q <= r1_cnt_q - SEC_W'(1);
			if (wd_trip & ~sw.relay2_latch_mode)
				r2_cnt_q <= SEC_W'(RELAY_PULSE_SEC + 1); // [RQ8]
			else if (r2_off)
				r2_cnt_q <= '0;
			else if (tick_q && r2_cnt_q != '0)
				r2_cnt_q <= r2_cnt_q - SEC_W'(1);
		end
	end

	wire r1_on = r1_latch_q | (r1_cnt_q != '0);
	wire r2_on = r2_latch_q | (r2_cnt_q != '0);

	// overtemp hold with hysteresis band input [RQ10] [RQ11]
	always_ff @(posedge pclk or negedge rst_n) begin
		if (!rst_n)
			ot_hold_q <= 1'b0;
		else if (sw.overtemp_hold_reset_enable & temp.upper_trip)
			ot_hold_q <= 1'b1; // [RQ10]
		else if (~temp.release_band | ~sw.overtemp_hold_reset_enable)
			ot_hold_q <= 1'b0; // [RQ11]
	end

	always_ff @(posedge pclk or negedge rst_n) begin
		if (!rst_n) begin
			hr_cnt_q   <= '0;
			rst_seen_q <= 1'b0;
			lower_q    <= 1'b0;
			ext_q      <= 1'b0;
		end else begin
			lower_q <= temp.lower_trip;
			ext_q   <= ext_trigger;
			if (wd_trip)
				hr_cnt_q <= 8'(HOST_RST_CYCLES); // [RQ23]
			else if (hr_cnt_q != '0)
				hr_cnt_q <= hr_cnt_q - 8'h01;
			if (wd_trip)
				rst_seen_q <= 1'b1; // [RQ21]
			else if (wr_c & pwdata[CTRL_CLR_RST])
				rst_seen_q <= 1'b0;
		end
	end

	always_ff @(posedge pclk or negedge rst_n) begin
		if (!rst_n) begin
			ctrl_q    <= CTRL_RESET;
			sw_to_q   <= TIMEOUT_RESET[SEC_W-1:0];
			sw_trig_q <= 1'b0;
			prdata    <= '0;
		end else begin
			sw_trig_q <= wr_g;
			if (wr_c)
				ctrl_q <= {29'h0, pwdata[CTRL_R2_VALUE:0]} | {26'h0, pwdata[CTRL_TO_OWN], 5'h0};
			if (wr_t)
				sw_to_q <= (pwdata[SEC_W-1:0] == '0) ? SEC_W'(1) : pwdata[SEC_W-1:0]; // [RQ17]
			if (psel & ~penable & ~pwrite) begin
				case (1'b1)
					hit_c: prdata <= ctrl_q;
					hit_s: prdata <= {22'h0, st_q, 1'b0, ot_hold_q, r2_on, rst_seen_q, relay2, relay1};
					hit_t: prdata <= {20'h0, timeout_s};
					default: prdata <= 32'h0000_0000;
				endcase
			end
		end
	end

	// host reset: panel pass-through, watchdog pulse, overtemp hold
	assign host_reset_n      = panel_reset_n & (hr_cnt_q == '0) & ~ot_hold_q; // [RQ18] [RQ10]
	assign relay1            = r1_on ^ ctrl_q[CTRL_R1_INVERT]; // [RQ6]
	assign relay2            = ctrl_q[CTRL_R2_OWN] ? ctrl_q[CTRL_R2_VALUE] : r2_on; // [RQ9]
	assign buzzer_continuous = temp.upper_trip & ~sw.overtemp_hold_reset_enable; // [RQ12]
	assign reset_seen_led    = rst_seen_q;

	chk_trip_sets_status: assert property (@(posedge pclk) disable iff (!rst_n)
		wd_trip |=> rst_seen_q) else $error("status not set after trip"); // [RQ21]
	chk_trip_host_rst: assert property (@(posedge pclk) disable iff (!rst_n)
		wd_trip |=> !host_reset_n [*8]) else $error("host reset pulse missing"); // [RQ23]
	chk_trip_to_hold: assert property (@(posedge pclk) disable iff (!rst_n)
		wd_trip |=> st_q == ST_HOLDOFF && sec_q == SEC_W'(STARTUP_SEC)) else $error("no startup delay"); // [RQ13]
	chk_retrig_reload: assert property (@(posedge pclk) disable iff (!rst_n)
		st_q == ST_ARMED && retrig |=> sec_q == $past(timeout_s)) else $error("retrigger no reload"); // [RQ16]
	chk_wait_needs_trig: assert property (@(posedge pclk) disable iff (!rst_n)
		st_q == ST_WAITTRG && !retrig |=> st_q == ST_WAITTRG) else $error("armed without trigger"); // [RQ14]
	chk_r2_owned: assert property (@(posedge pclk) disable iff (!rst_n)
		ctrl_q[CTRL_R2_OWN] |-> relay2 == ctrl_q[CTRL_R2_VALUE]) else $error("relay two not owned"); // [RQ9]
	chk_r1_latch: assert property (@(posedge pclk) disable iff (!rst_n)
		r1_fire && r1_latch_sel |=> r1_latch_q) else $error("relay one not latched"); // [RQ3]
	chk_r2_pulse: assert property (@(posedge pclk) disable iff (!rst_n)
		wd_trip && !sw.relay2_latch_mode |=> r2_cnt_q == SEC_W'(RELAY_PULSE_SEC + 1)) else $error("relay two pulse"); // [RQ8]
	chk_ot_hold: assert property (@(posedge pclk) disable iff (!rst_n)
		ot_hold_q |-> !host_reset_n) else $error("overtemp hold lost"); // [RQ10]
endmodule : switch_configured_watchdog

// ==== bench/host_side_model.sv ====
`timescale 1ns/1ps
module host_side_model (
	// clock
	input  wire logic pclk,
	// host side
	input  wire logic host_reset_n,
	input  wire logic kick,
	output logic      ext_trigger,
	output int        resets
);
	initial begin
		ext_trigger = 1'b0;
		resets      = 0;
	end
	// one kick cycle gives one clean rising edge, well inside the timeout
	always @(posedge pclk) begin
		ext_trigger <= kick;
	end
	always @(negedge host_reset_n) begin
		resets <= resets + 1;
	end
endmodule : host_side_model

// ==== bench/switch_configured_watchdog_bench.sv ====
`timescale 1ns/1ps
module switch_configured_watchdog_bench;
	import wdog_pkg::*;
	localparam int unsigned TC = 20;
	logic        pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, kick = 0, panel_reset_n = 1;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h0000_0000, prdata, rd;
	logic [3:0]  pstrb = 4'hf;
	logic        pready, pslverr, err, host_reset_n, relay1, relay2, buzzer_continuous, reset_seen_led, ext_trigger;
	switches_t   sw = '0;
	temp_t       temp = '0;
	int          fail_count = 0, num_checks = 0, resets, n, h;
	// delay select beside the timeout it should read back
	logic [14:0] rows [8] = '{15'h0005, 15'h100a, 15'h201e, 15'h303c, 15'h412c, 15'h5258, 15'h6708, 15'h7e10};

	always #25 pclk = ~pclk;

	switch_configured_watchdog #(.TICK_CYC(TC)) switch_configured_watchdog_inst (.pclk, .presetn, .psel, .penable,
		.pwrite, .paddr, .pwdata, .pstrb, .prdata, .pready, .pslverr, .sw, .temp, .ext_trigger, .panel_reset_n,
		.host_reset_n, .relay1, .relay2, .buzzer_continuous, .reset_seen_led);
	host_side_model host_side_model_inst (.pclk, .host_reset_n, .kick, .ext_trigger, .resets);

	task automatic end_of_test();
		$display("checks=%0d mismatches=%0d", num_checks, fail_count);
		if (fail_count == 0 && num_checks > 0) $display("Finished cleanly");
		else $display("Finished with errors");
		$finish;
	endtask : end_of_test

	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		num_checks++;
		if (seen !== exp) begin
			fail_count++;
			$display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask : chk

	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		int k;
		k = 0;
		psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do begin
			@(posedge pclk);
			k++;
		end while (pready !== 1'b1 && k < 50);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0; penable <= 1'b0;
		if (k >= 50) begin
			fail_count++;
			end_of_test();
		end
		@(posedge pclk);
	endtask : apb

	// bounded wait for the host reset line to reach a level
	task automatic wait_hr(input logic v, input int max);
		int k;
		k = 0;
		while (host_reset_n !== v && k < max) begin
			@(posedge pclk);
			k++;
		end
		if (host_reset_n !== v) begin
			fail_count++;
			end_of_test();
		end
	endtask : wait_hr

	initial begin
		repeat (12) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		chk({host_reset_n, relay1, relay2}, 32'h0000_0004);
		apb(0, ADDR_CTRL, 0); chk(rd, CTRL_RESET);
		foreach (rows[i]) begin
			sw.delay_sel <= rows[i][14:12];
			@(posedge pclk);
			apb(0, ADDR_TIMEOUT, 0); chk(rd, {20'h0_0000, rows[i][11:0]});
		end
		sw.delay_sel <= 3'h0;
		apb(1, ADDR_TIMEOUT, 32'h0000_0007);
		apb(1, ADDR_CTRL, 32'h0000_0020);
		apb(0, ADDR_TIMEOUT, 0); chk(rd, 32'h0000_0007);
		apb(1, ADDR_CTRL, 32'h0000_0000);
		// extend switch stays off here, the safe setting for the host
		// kicks every 40 cycles keep an armed 5 s count from expiring
		for (n = 0; n < 150 * TC + 400; n += 40) begin
			kick <= 1'b1;
			@(posedge pclk);
			kick <= 1'b0;
			repeat (39) @(posedge pclk);
		end
		chk(resets, 1'b0);
		wait_hr(0, 5 * TC + 40);
		n = 0;
		h = 1;
		while (relay1 === 1'b1 && n < 200) begin
			@(posedge pclk);
			n++;
			h += !host_reset_n;
		end
		chk(32'(n >= 4 * TC - 2 && n <= 5 * TC + 2), 1);
		chk(32'(h >= HOST_RST_CYCLES - 1 && h <= HOST_RST_CYCLES + 1), 1);
		chk({relay1, relay2, host_reset_n}, 32'h0000_0001);
		apb(0, ADDR_STATUS, 0); chk({rd[2], reset_seen_led}, 32'h0000_0003);
		apb(1, ADDR_CTRL, 32'h0000_0040);
		apb(0, ADDR_STATUS, 0); chk(rd[2], 0);
		sw <= '{relay1_latch_mode: 1, relay2_latch_mode: 1, startup_hold_delay: 1, default: 0};
		repeat (150 * TC + 300) @(posedge pclk);
		chk(resets, 1);
		kick <= 1'b1;
		@(posedge pclk);
		kick <= 1'b0;
		wait_hr(0, 5 * TC + 40);
		wait_hr(1, 40);
		repeat (6 * TC) @(posedge pclk);
		chk({relay1, relay2}, 32'h0000_0003);
		apb(1, ADDR_CTRL, 32'h0000_0018);
		chk({relay1, relay2}, 0);
		sw.relay1_temp_enable <= 1'b1;
		temp.lower_trip <= 1'b1;
		repeat (4) @(posedge pclk);
		chk({relay1, relay2}, 32'h0000_0002);
		apb(1, ADDR_CTRL, 32'h0000_0006); chk(relay2, 1);
		apb(1, ADDR_CTRL, 32'h0000_0002); chk(relay2, 0);
		// invert on: latch cleared, sense flipped, mode flipped to pulse
		apb(1, ADDR_CTRL, 32'h0000_0009); chk(relay1, 1);
		temp.lower_trip <= 1'b0;
		repeat (2) @(posedge pclk);
		temp.lower_trip <= 1'b1;
		repeat (3) @(posedge pclk);
		chk(relay1, 0);
		sw.overtemp_hold_reset_enable <= 1'b1;
		temp <= 3'h7;
		wait_hr(0, 5);
		repeat (30) @(posedge pclk);
		chk(host_reset_n, 0);
		temp <= 3'h4;
		wait_hr(1, 5);
		sw.overtemp_hold_reset_enable <= 1'b0;
		temp <= 3'h6;
		repeat (4) @(posedge pclk);
		chk({buzzer_continuous, host_reset_n}, 32'h0000_0003);
		apb(0, 12'h010, 0); chk(err, 1);
		chk(rd, 0);
		panel_reset_n <= 1'b0;
		repeat (2) @(posedge pclk);
		chk({host_reset_n, relay1, relay2, reset_seen_led}, 0);
		panel_reset_n <= 1'b1;
		end_of_test();
	end
endmodule : switch_configured_watchdog_bench
